// ---- hw/lamp_pkg.sv ----
// constants, register map and carrier types for the status lamp driver
package lamp_pkg;
    // time base: one pattern tick per millisecond
    localparam int CLK_MHZ      = 200;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
    localparam int TICK_W       = 18;
    localparam int PAT_W        = 11;
    // lamp pattern timing in milliseconds, blink rates in hertz (run blink in tenths of a hertz)
    localparam int RUN_BLINK_HZ_X10 = 25;
    localparam int BLINK_HALF_MS    = 5000 / RUN_BLINK_HZ_X10;
    localparam int FLASH_ON_MS      = 200;
    localparam int FLASH_OFF_MS     = 1000;
    localparam int LOAD_SLOW_HZ     = 1;
    localparam int LOAD_FAST_HZ     = 6;
    localparam int SLOW_HALF_MS     = 1000 / (2 * LOAD_SLOW_HZ);
    localparam int FAST_HALF_MS     = 1000 / (2 * LOAD_FAST_HZ);
    localparam int FLICK_HALF_MS    = 50;
    localparam int ACT_HOLD_MS      = 100;
    localparam int HOLD_W           = 7;
    // pattern generator indices
    localparam int PAT_FLICK  = 0;
    localparam int PAT_BLINK  = 1;
    localparam int PAT_SINGLE = 2;
    localparam int PAT_DOUBLE = 3;
    localparam int PAT_SLOW   = 4;
    localparam int PAT_FAST   = 5;
    localparam int NPAT       = 6;
    localparam int PAT_PERIOD [NPAT] = '{
        2 * FLICK_HALF_MS,
        2 * BLINK_HALF_MS,
        FLASH_ON_MS + FLASH_OFF_MS,
        3 * FLASH_ON_MS + FLASH_OFF_MS,
        2 * SLOW_HALF_MS,
        2 * FAST_HALF_MS
    };
    // register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_CAUSE   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS  = 8'h08;
    localparam int          CTRL_W       = 17;
    localparam int          STICKY_BIT   = 7;
    localparam logic [7:0]  AL_CHANGE_ERR = 8'h01;
    localparam logic [31:0] CAUSE_RESET  = 32'h0000_0000;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 17'h0_0000;

    typedef enum logic [1:0] {NET_INIT, NET_PREOP, NET_SAFEOP, NET_OP} net_state_t;

    // control word as written by software
    typedef struct packed {
        logic [7:0] al_change;
        logic       fatal;
        logic       pdi_fail;
        logic       wd_timeout;
        logic       cfg_err;
        logic       loader_busy;
        logic       loader_run;
        logic       started;
        net_state_t state;
    } ctrl_t;

    // lamp drive, high lights the lamp
    typedef struct packed {
        logic link_a;
        logic link_b;
        logic run_green;
        logic run_red;
        logic err_red;
    } lamps_t;
endpackage : lamp_pkg

// ---- hw/status_lamp_driver.sv ----
// status lamp pattern driver with register port and fault forwarding
// Notes on behaviour
// - a link lamp is dark when its port has no link or the controller is not started.
// - a link lamp is steady green with a link and no traffic.
// - a link lamp flickers green while frames pass on its port.
// - the green run lamp is dark in the initialisation state.
// - the green run lamp blinks at about 2.5 Hz in pre-operational state.
// - in safe-operational state the green run lamp single-flashes 200 ms on, 1000 ms off.
// - the green run lamp is steady in operational state.
// - while the loader runs the run lamp blinks red, 1 Hz idle and 6 Hz busy.
// - the error lamp is dark without error and blinks on a configuration error.
// - an application state change with code 0x01 makes the error lamp single-flash.
// - a watchdog timeout makes the error lamp double-flash.
// - a data interface failure or fatal event lights the error lamp steadily; cause readable.
// - while the loader runs and no fault is set the error lamp also blinks at 1 Hz idle, 6 Hz busy.
// - every fault is forwarded both to the drive and to the network master.
// - the red run colour is used only by the loader, otherwise green.
`timescale 1ns/10ps
`default_nettype none

module status_lamp_driver #(
    parameter int TICK_CYCLES = lamp_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst,
    // register port
    input  wire logic [7:0]      reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata,
    // physical port status pins
    input  wire logic [1:0]      link_up,
    input  wire logic [1:0]      link_act,
    // lamps
    output lamp_pkg::lamps_t     lamps,
    // fault forwarding
    output logic                 fault_to_drive,
    output logic                 fault_to_master
);
    import lamp_pkg::*;

    ctrl_t              ctrl_q;
    logic [31:0]        cause_q;
    logic               sticky_q;
    logic [31:0]        rdata_q;
    logic [1:0]         up_meta_q;
    logic [1:0]         up_sync_q;
    logic [1:0]         act_meta_q;
    logic [1:0]         act_sync_q;
    logic [1:0]         act_prev_q;
    logic [TICK_W-1:0]  tick_cnt_q;
    logic               tick_q;
    logic [PAT_W-1:0]   pat_cnt_q [NPAT];
    logic [NPAT-1:0]    pat_on;
    logic [HOLD_W-1:0]  hold_q [2];
    lamps_t             lamps_d;
    lamps_t             lamps_q;
    logic               fault_any;
    logic               fault_q;
    logic               al_changed;
    logic               loader_pat;

    // register writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q  <= ctrl_t'(CTRL_RESET);
            cause_q <= CAUSE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CTRL) begin
                ctrl_q <= ctrl_t'(reg_wdata[CTRL_W-1:0]);
            end
            if (reg_addr == ADDR_CAUSE) begin
                cause_q <= reg_wdata;
            end
        end
    end

    // sticky fault flag, a new fault wins over the clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sticky_q <= 1'b0;
        end else if (fault_any) begin
            sticky_q <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STICKY_BIT]) begin
            sticky_q <= 1'b0;
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL:   rdata_q <= {15'h0000, ctrl_q};
                ADDR_CAUSE:  rdata_q <= cause_q;
                ADDR_STATUS: rdata_q <= {24'h00_0000, sticky_q, fault_q,
                                         up_sync_q, lamps_q.link_a, lamps_q.run_green,
                                         lamps_q.run_red, lamps_q.err_red};
                default:     rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    // two-stage synchronisers for the port pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            up_meta_q  <= 2'h0;
            up_sync_q  <= 2'h0;
            act_meta_q <= 2'h0;
            act_sync_q <= 2'h0;
            act_prev_q <= 2'h0;
        end else begin
            up_meta_q  <= link_up;
            up_sync_q  <= up_meta_q;
            act_meta_q <= link_act;
            act_sync_q <= act_meta_q;
            act_prev_q <= act_sync_q;
        end
    end

    // millisecond tick divider
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    // one millisecond counter per pattern period
    for (genvar i = 0; i < NPAT; i++) begin : g_pat
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pat_cnt_q[i] <= '0;
            end else if (tick_q) begin
                if (pat_cnt_q[i] == PAT_W'(PAT_PERIOD[i] - 1)) begin
                    pat_cnt_q[i] <= '0;
                end else begin
                    pat_cnt_q[i] <= pat_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // pattern phases, each period opens with its off phase
    always_comb begin
        pat_on[PAT_FLICK]  = pat_cnt_q[PAT_FLICK] >= PAT_W'(FLICK_HALF_MS);
        pat_on[PAT_BLINK]  = pat_cnt_q[PAT_BLINK] >= PAT_W'(BLINK_HALF_MS);
        pat_on[PAT_SINGLE] = pat_cnt_q[PAT_SINGLE] >= PAT_W'(FLASH_OFF_MS);
        pat_on[PAT_DOUBLE] = (pat_cnt_q[PAT_DOUBLE] >= PAT_W'(FLASH_OFF_MS)
                              && pat_cnt_q[PAT_DOUBLE] < PAT_W'(FLASH_OFF_MS + FLASH_ON_MS))
                             || pat_cnt_q[PAT_DOUBLE]
                                >= PAT_W'(FLASH_OFF_MS + 2 * FLASH_ON_MS);
        pat_on[PAT_SLOW]   = pat_cnt_q[PAT_SLOW] >= PAT_W'(SLOW_HALF_MS);
        pat_on[PAT_FAST]   = pat_cnt_q[PAT_FAST] >= PAT_W'(FAST_HALF_MS);
    end

    // traffic stretch per port so short frames stay visible
    for (genvar p = 0; p < 2; p++) begin : g_act
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                hold_q[p] <= '0;
            end else if (act_sync_q[p] != act_prev_q[p] || act_sync_q[p]) begin
                hold_q[p] <= HOLD_W'(ACT_HOLD_MS);
            end else if (tick_q && hold_q[p] != '0) begin
                hold_q[p] <= hold_q[p] - 1'b1;
            end
        end
    end

    assign al_changed = ctrl_q.al_change == AL_CHANGE_ERR;
    assign loader_pat = ctrl_q.loader_busy ? pat_on[PAT_FAST] : pat_on[PAT_SLOW];
    assign fault_any  = ctrl_q.pdi_fail | ctrl_q.fatal | ctrl_q.wd_timeout
                      | al_changed | ctrl_q.cfg_err;

    // lamp selection
    always_comb begin
        lamps_d = '0;
        // link lamps
        if (up_sync_q[0] && ctrl_q.started) begin
            lamps_d.link_a = (hold_q[0] != '0) ? pat_on[PAT_FLICK] : 1'b1;
        end else begin
            lamps_d.link_a = 1'b0;
        end
        if (up_sync_q[1] && ctrl_q.started) begin
            lamps_d.link_b = (hold_q[1] != '0) ? pat_on[PAT_FLICK] : 1'b1;
        end else begin
            lamps_d.link_b = 1'b0;
        end
        // run lamp, red only while the loader runs
        if (ctrl_q.loader_run) begin
            lamps_d.run_red   = loader_pat;
            lamps_d.run_green = 1'b0;
        end else begin
            lamps_d.run_red = 1'b0;
            unique case (ctrl_q.state)
                NET_INIT:   lamps_d.run_green = 1'b0;
                NET_PREOP:  lamps_d.run_green = pat_on[PAT_BLINK];
                NET_SAFEOP: lamps_d.run_green = pat_on[PAT_SINGLE];
                NET_OP:     lamps_d.run_green = 1'b1;
            endcase
        end
        // error lamp, most severe first
        if (ctrl_q.pdi_fail || ctrl_q.fatal) begin
            lamps_d.err_red = 1'b1;
        end else if (ctrl_q.wd_timeout) begin
            lamps_d.err_red = pat_on[PAT_DOUBLE];
        end else if (al_changed) begin
            lamps_d.err_red = pat_on[PAT_SINGLE];
        end else if (ctrl_q.cfg_err) begin
            lamps_d.err_red = pat_on[PAT_BLINK];
        end else if (ctrl_q.loader_run) begin
            lamps_d.err_red = loader_pat;
        end else begin
            lamps_d.err_red = 1'b0;
        end
    end

    // registered lamp drive and fault forwarding
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lamps_q <= '0;
            fault_q <= 1'b0;
        end else begin
            lamps_q <= lamps_d;
            fault_q <= fault_any;
        end
    end

    assign lamps           = lamps_q;
    assign fault_to_drive  = fault_q;
    assign fault_to_master = fault_q;

    // link lamp dark without link or start
    a_link_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!up_sync_q[0] || !ctrl_q.started) |=> !lamps.link_a)
        else $error("link lamp a lit without link");

    // link lamp steady with link and no traffic
    a_link_steady_b: assert property (@(posedge sys_clk) disable iff (rst)
        (up_sync_q[1] && ctrl_q.started && hold_q[1] == '0) |=> lamps.link_b)
        else $error("link lamp b not steady on idle link");

    // link lamp follows the flicker counter while traffic is stretched
    a_link_flicker_b: assert property (@(posedge sys_clk) disable iff (rst)
        (up_sync_q[1] && ctrl_q.started && hold_q[1] != '0)
        |=> lamps.link_b == ($past(pat_cnt_q[PAT_FLICK]) >= PAT_W'(FLICK_HALF_MS)))
        else $error("link lamp b not flickering on traffic");

    // traffic restarts the stretch to its full length
    a_act_hold_load: assert property (@(posedge sys_clk) disable iff (rst)
        act_sync_q[0] |=> hold_q[0] == HOLD_W'(ACT_HOLD_MS))
        else $error("traffic stretch not reloaded");

    // run lamp in init and operational states
    a_run_init_dark: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.loader_run && ctrl_q.state == NET_INIT) |=> !lamps.run_green)
        else $error("run lamp lit in init state");

    a_run_op_lit: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.loader_run && ctrl_q.state == NET_OP) |=> lamps.run_green)
        else $error("run lamp dark in operational state");

    // pre-operational blink taken from its own counter
    a_run_preop_blink: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.loader_run && ctrl_q.state == NET_PREOP)
        |=> lamps.run_green == ($past(pat_cnt_q[PAT_BLINK]) >= PAT_W'(BLINK_HALF_MS)))
        else $error("run lamp not blinking in pre-operational state");

    // safe-operational flash lit only in the last part of its period
    a_single_flash_on: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.loader_run && ctrl_q.state == NET_SAFEOP)
        |=> lamps.run_green == ($past(pat_cnt_q[PAT_SINGLE]) >= PAT_W'(FLASH_OFF_MS)))
        else $error("single flash phase wrong");

    // red run colour only from the loader
    a_red_run_loader: assert property (@(posedge sys_clk) disable iff (rst)
        lamps.run_red |-> $past(ctrl_q.loader_run) && !lamps.run_green)
        else $error("red run lamp without loader");

    // busy loader blink follows the fast rate
    a_loader_fast_rate: assert property (@(posedge sys_clk) disable iff (rst)
        (ctrl_q.loader_run && ctrl_q.loader_busy) |=> lamps.run_red == $past(pat_on[PAT_FAST]))
        else $error("busy loader not at fast rate");

    // error lamp steady on data interface or fatal fault
    a_err_steady_on: assert property (@(posedge sys_clk) disable iff (rst)
        (ctrl_q.pdi_fail || ctrl_q.fatal) |=> lamps.err_red)
        else $error("error lamp not steady on failure");

    // watchdog outranks application change
    a_err_double_prio: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.pdi_fail && !ctrl_q.fatal && ctrl_q.wd_timeout && al_changed)
        |=> lamps.err_red == $past(pat_on[PAT_DOUBLE]))
        else $error("error lamp priority wrong");

    // application change single flash when nothing more severe holds
    a_err_single_flash: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.pdi_fail && !ctrl_q.fatal && !ctrl_q.wd_timeout && al_changed)
        |=> lamps.err_red == ($past(pat_cnt_q[PAT_SINGLE]) >= PAT_W'(FLASH_OFF_MS)))
        else $error("error lamp not single flashing on state change");

    // configuration error blink below the flash patterns
    a_err_cfg_blink: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctrl_q.pdi_fail && !ctrl_q.fatal && !ctrl_q.wd_timeout
         && !al_changed && ctrl_q.cfg_err)
        |=> lamps.err_red == ($past(pat_cnt_q[PAT_BLINK]) >= PAT_W'(BLINK_HALF_MS)))
        else $error("error lamp not blinking on configuration error");

    // error lamp dark without any fault or loader
    a_err_clean_dark: assert property (@(posedge sys_clk) disable iff (rst)
        (!fault_any && !ctrl_q.loader_run) |=> !lamps.err_red)
        else $error("error lamp lit without fault");

    // idle loader blinks the error lamp at the slow rate
    a_err_loader_blink: assert property (@(posedge sys_clk) disable iff (rst)
        (!fault_any && ctrl_q.loader_run && !ctrl_q.loader_busy)
        |=> lamps.err_red == ($past(pat_cnt_q[PAT_SLOW]) >= PAT_W'(SLOW_HALF_MS)))
        else $error("error lamp not at idle loader rate");

    // faults reach both parties one cycle later
    a_fault_forward: assert property (@(posedge sys_clk) disable iff (rst)
        fault_any |=> fault_to_drive && fault_to_master && sticky_q)
        else $error("fault not forwarded");

    // forwarded fault drops once every condition is gone
    a_fault_release: assert property (@(posedge sys_clk) disable iff (rst)
        !fault_any |=> !fault_to_drive && !fault_to_master)
        else $error("fault still forwarded without cause");

    // patterns restart from the off phase after reset
    a_pat_reset_off: assert property (@(posedge sys_clk)
        rst |=> pat_cnt_q[PAT_DOUBLE] == '0 && !pat_on[PAT_DOUBLE])
        else $error("pattern not restarted by reset");

endmodule : status_lamp_driver

`default_nettype wire

// ---- bench/lamp_watch.sv ----
// operator view of one lamp: run lengths and edge count
`timescale 1ns/10ps
`default_nettype none

module lamp_watch (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // observation control and lamp
    input  wire logic        clr,
    input  wire logic        lamp,
    // edge count and measured run lengths in clock cycles
    output logic [15:0]      edges,
    output logic [15:0]      on_max,
    output logic [15:0]      off_min,
    output logic [15:0]      off_max
);
    logic [15:0] run_q;
    logic        prev_q;
    logic        seen_q;

    // runs are only recorded once a first edge is seen, so partial runs never count
    always_ff @(posedge sys_clk) begin
        if (rst || clr) begin
            run_q   <= 16'h0001;
            prev_q  <= lamp;
            seen_q  <= 1'b0;
            edges   <= 16'h0000;
            on_max  <= 16'h0000;
            off_min <= 16'hffff;
            off_max <= 16'h0000;
        end else if (lamp != prev_q) begin
            prev_q <= lamp;
            run_q  <= 16'h0001;
            edges  <= edges + 16'h0001;
            seen_q <= 1'b1;
            if (seen_q && prev_q && run_q > on_max) begin
                on_max <= run_q;
            end
            if (seen_q && !prev_q && run_q < off_min) begin
                off_min <= run_q;
            end
            if (seen_q && !prev_q && run_q > off_max) begin
                off_max <= run_q;
            end
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end
endmodule : lamp_watch

`default_nettype wire

// ---- bench/fieldbus_status_led_driver_bench.sv ----
// self-checking bench for the status lamp driver
`timescale 1ns/10ps
`default_nettype none

module fieldbus_status_led_driver_bench;
    import lamp_pkg::*;
    localparam int TK = 4;
    localparam int CYC_MAX = 90000;
    localparam int LA = 4, LB = 3, RG = 2, RR = 1, ER = 0;

    logic sys_clk, rst, reg_wr, reg_rd, clr, fault_to_drive, fault_to_master;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    logic [1:0] link_up, link_act;
    lamps_t lamps;
    logic [4:0] lamps_v;
    logic [4:0][15:0] edges_v, on_max_v, off_min_v, off_max_v;
    ctrl_t ctrl;
    int error_cnt, checks_done, cyc;

    assign lamps_v = lamps;

    // device under test with a short millisecond tick
    status_lamp_driver #(.TICK_CYCLES(TK)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
        .link_act(link_act), .lamps(lamps), .fault_to_drive(fault_to_drive),
        .fault_to_master(fault_to_master)
    );

    // one watcher per lamp
    lamp_watch u_watch [4:0] (
        .sys_clk(sys_clk), .rst(rst), .clr(clr), .lamp(lamps_v), .edges(edges_v),
        .on_max(on_max_v), .off_min(off_min_v), .off_max(off_max_v)
    );

    // clock generation
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_MAX) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the read edge, taken at its closing edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd

    // write control word, let it settle, then observe for ms milliseconds
    task automatic apply(input int ms);
        wr(ADDR_CTRL, 32'(ctrl));
        repeat (8) @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (ms * TK) @(posedge sys_clk);
    endtask : apply

    task automatic pat(input int i, input int on_ms, input int lo_ms, input int hi_ms);
        chk({16'h0, on_max_v[i]}, 32'(on_ms * TK));
        chk({16'h0, off_min_v[i]}, 32'(lo_ms * TK));
        chk({16'h0, off_max_v[i]}, 32'(hi_ms * TK));
    endtask : pat

    task automatic steady(input int i, input logic lvl);
        chk({16'h0, edges_v[i]}, 32'h0);
        chk({31'h0, lamps_v[i]}, {31'h0, lvl});
    endtask : steady

    // main sequence
    initial begin
        rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
        link_up = 2'b00; link_act = 2'b00; clr = 1'b0; ctrl = '0;
        error_cnt = 0;
        checks_done = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({27'h0, lamps}, 32'h0);
        rd(ADDR_CTRL, rdv); chk(rdv, {15'h0, CTRL_RESET});
        rd(ADDR_CAUSE, rdv); chk(rdv, CAUSE_RESET);
        link_up <= 2'b01;
        apply(50); steady(LA, 1'b0);
        ctrl.started = 1'b1;
        apply(50); steady(LA, 1'b1);
        steady(LB, 1'b0);
        link_act <= 2'b01;
        apply(300); pat(LA, FLICK_HALF_MS, FLICK_HALF_MS, FLICK_HALF_MS);
        link_act <= 2'b00;
        repeat (150 * TK) @(posedge sys_clk);
        apply(50); steady(LA, 1'b1);
        ctrl.state = NET_INIT;
        apply(50); steady(RG, 1'b0);
        ctrl.state = NET_PREOP;
        apply(1000); pat(RG, BLINK_HALF_MS, BLINK_HALF_MS, BLINK_HALF_MS);
        ctrl.state = NET_SAFEOP;
        apply(3000); pat(RG, FLASH_ON_MS, FLASH_OFF_MS, FLASH_OFF_MS);
        steady(RR, 1'b0);
        ctrl.state = NET_OP;
        apply(50); steady(RG, 1'b1);
        ctrl.loader_run = 1'b1;
        apply(2500); pat(RR, SLOW_HALF_MS, SLOW_HALF_MS, SLOW_HALF_MS);
        pat(ER, SLOW_HALF_MS, SLOW_HALF_MS, SLOW_HALF_MS);
        steady(RG, 1'b0);
        ctrl.loader_busy = 1'b1;
        apply(500); pat(RR, FAST_HALF_MS, FAST_HALF_MS, FAST_HALF_MS);
        pat(ER, FAST_HALF_MS, FAST_HALF_MS, FAST_HALF_MS);
        ctrl.loader_run = 1'b0; ctrl.loader_busy = 1'b0;
        apply(50); steady(ER, 1'b0);
        chk({30'h0, fault_to_drive, fault_to_master}, 32'h0);
        ctrl.cfg_err = 1'b1;
        apply(1000); pat(ER, BLINK_HALF_MS, BLINK_HALF_MS, BLINK_HALF_MS);
        ctrl.al_change = AL_CHANGE_ERR;
        apply(3000); pat(ER, FLASH_ON_MS, FLASH_OFF_MS, FLASH_OFF_MS);
        ctrl.wd_timeout = 1'b1;
        apply(4000); pat(ER, FLASH_ON_MS, FLASH_ON_MS, FLASH_OFF_MS);
        chk({30'h0, fault_to_drive, fault_to_master}, 32'h3);
        ctrl.pdi_fail = 1'b1;
        apply(50); steady(ER, 1'b1);
        ctrl = '0; ctrl.started = 1'b1; ctrl.state = NET_OP; ctrl.fatal = 1'b1;
        apply(50); steady(ER, 1'b1);
        chk({30'h0, fault_to_drive, fault_to_master}, 32'h3);
        wr(ADDR_CAUSE, 32'h5a5a_0f0f);
        rd(ADDR_CAUSE, rdv); chk(rdv, 32'h5a5a_0f0f);
        ctrl.fatal = 1'b0;
        apply(50); steady(ER, 1'b0);
        chk({30'h0, fault_to_drive, fault_to_master}, 32'h0);
        rd(ADDR_STATUS, rdv); chk(rdv & 32'hc0, 32'h80);
        wr(ADDR_STATUS, 32'h80);
        rd(ADDR_STATUS, rdv); chk(rdv & 32'hc0, 32'h0);
        rd(8'h0c, rdv); chk(rdv, 32'h0);
        // second port: traffic on b only, then b idle
        link_up <= 2'b11;
        link_act <= 2'b10;
        apply(300); pat(LB, FLICK_HALF_MS, FLICK_HALF_MS, FLICK_HALF_MS);
        steady(LA, 1'b1);
        link_act <= 2'b00;
        repeat (150 * TK) @(posedge sys_clk);
        apply(50); steady(LB, 1'b1);
        rd(ADDR_STATUS, rdv); chk(rdv & 32'h30, 32'h30);
        wrap_up();
    end
endmodule : fieldbus_status_led_driver_bench

`default_nettype wire
